/* File: srtc_defs.svh */
// Purpose: Constants for the serial RTC access host controller.
// Assumes: 100 MHz core clock, 32-bit AXI4-Lite register port.
// Notes: Offsets are byte addresses of one aligned word each.
`ifndef SRTC_DEFS_SVH
`define SRTC_DEFS_SVH
`define SRTC_OFF_CTRL 8'h00
`define SRTC_OFF_STATUS 8'h04
`define SRTC_OFF_KEY_LO 8'h08
`define SRTC_OFF_KEY_HI 8'h0c
`define SRTC_OFF_TIME_LO 8'h10
`define SRTC_OFF_TIME_HI 8'h14
`define SRTC_OFF_RD_LO 8'h18
`define SRTC_OFF_RD_HI 8'h1c
`define SRTC_CTRL_GO 0
`define SRTC_CTRL_WRITE 1
`define SRTC_STAT_BUSY 0
`define SRTC_STAT_DONE 1
`define SRTC_KEY_RESET 64'h0000000000000000
`define SRTC_PHASE_NS 70
`define SRTC_CLK_NS 10
`define SRTC_PHASE_CYC ((`SRTC_PHASE_NS + `SRTC_CLK_NS - 1) / `SRTC_CLK_NS)
`define SRTC_PATTERN_BITS 64
`define SRTC_DATA_BITS 64
`define SRTC_HOUR_FMT_BIT 7
`define SRTC_HOUR_PM_BIT 5
`define SRTC_DAY_RSTMASK_BIT 4
`define SRTC_DAY_HALT_BIT 5
`endif

/* File: srtc_pkg.sv */
// Purpose: Types shared by the serial RTC host controller files.
// Assumes: Nothing beyond the constants header.
// Notes: Types only; numbers live in the header.
package srtc_pkg;
	typedef enum logic [1:0] {SRTC_CYC_READ, SRTC_CYC_WRITE} srtc_cyc_e;
	typedef enum {SRTC_IDLE, SRTC_SYNC_RD, SRTC_KEY, SRTC_DATA, SRTC_FIN} srtc_seq_e;
endpackage

/* File: srtc_cyc_if.sv */
// Purpose: Request/answer link between sequencer and bus-cycle engine.
// Assumes: One core clock.
// Notes: A request is held until done pulses.
`timescale 1ns/1ns
interface srtc_cyc_if;
	logic req;
	srtc_pkg::srtc_cyc_e kind;
	logic wbit;
	logic done;
	logic rbit;
	modport seq (output req, output kind, output wbit, input done, input rbit);
	modport eng (input req, input kind, input wbit, output done, output rbit);
endinterface

/* File: srtc_cycle.sv */
// Purpose: Runs one SRAM-style strobe cycle carrying a single bit on the data line.
// Assumes: Request held stable until done; serial data input already synchronised.
// Notes: Each strobe phase lasts a whole number of core cycles.
`timescale 1ns/1ns
`include "srtc_defs.svh"
module srtc_cycle
(
	input wire logic core_clk,
	input wire logic resetn,
	srtc_cyc_if.eng cyc,
	input wire logic sdata_in,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic sdata_out,
	output logic sdata_oe
);
	localparam logic [7:0] PHASE = 8'(`SRTC_PHASE_CYC);
	logic [7:0] cnt_r, cnt_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, do_r, do_nxt, doe_r, doe_nxt;
	logic done_r, done_nxt, rb_r, rb_nxt;

	// Phase 0 idle, 1 strobe low, 2 recovery; the read bit is sampled at strobe end.
	always_comb
	begin
		cnt_nxt = cnt_r;
		ph_nxt = ph_r;
		ce_nxt = ce_r;
		oe_nxt = oe_r;
		we_nxt = we_r;
		do_nxt = do_r;
		doe_nxt = doe_r;
		done_nxt = 1'b0;
		rb_nxt = rb_r;
		case (ph_r)
			2'd0:
			begin
				if (cyc.req && !done_r)
				begin
					ph_nxt = 2'd1;
					cnt_nxt = PHASE;
					ce_nxt = 1'b0;
					oe_nxt = (cyc.kind != srtc_pkg::SRTC_CYC_READ);
					we_nxt = (cyc.kind != srtc_pkg::SRTC_CYC_WRITE);
					do_nxt = cyc.wbit;
					doe_nxt = (cyc.kind == srtc_pkg::SRTC_CYC_WRITE);
				end
			end
			2'd1:
			begin
				if (cnt_r == 8'd1)
				begin
					ph_nxt = 2'd2;
					cnt_nxt = PHASE;
					ce_nxt = 1'b1;
					oe_nxt = 1'b1;
					we_nxt = 1'b1;
					rb_nxt = sdata_in;
				end
				else
					cnt_nxt = cnt_r - 8'd1;
			end
			default:
			begin
				if (cnt_r == 8'd1)
				begin
					ph_nxt = 2'd0;
					doe_nxt = 1'b0;
					done_nxt = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 8'd1;
			end
		endcase
	end

	// Strobes reset high so the device sees no cycle while we are in reset.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			cnt_r <= 8'h00;
			ph_r <= 2'd0;
			ce_r <= 1'b1;
			oe_r <= 1'b1;
			we_r <= 1'b1;
			do_r <= 1'b0;
			doe_r <= 1'b0;
			done_r <= 1'b0;
			rb_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			ph_r <= ph_nxt;
			ce_r <= ce_nxt;
			oe_r <= oe_nxt;
			we_r <= we_nxt;
			do_r <= do_nxt;
			doe_r <= doe_nxt;
			done_r <= done_nxt;
			rb_r <= rb_nxt;
		end
	end

	assign chip_en_n = ce_r;
	assign out_en_n = oe_r;
	assign wr_en_n = we_r;
	assign sdata_out = do_r;
	assign sdata_oe = doe_r;
	assign cyc.done = done_r;
	assign cyc.rbit = rb_r;
endmodule

/* File: srtc_host.sv */
// Purpose: Host controller that unlocks a serial RTC behind an SRAM port and moves its 64 bits.
// Assumes: Software loads the unlock key and time image over AXI4-Lite, then sets go.
// Notes: The abort pin is driven high always; the device's own abort is not used here.
// Notes: Bus ready outputs are flops that look one cycle ahead, so no output is combinational.
`timescale 1ns/1ns
`include "srtc_defs.svh"
// Operation
// - Host always writes whole registers; a full 64-bit image per transfer.
// - Bits go from register 0 bit 0 up to register 7 bit 7.
// - Unlock key is sent least significant bit first.
// - Host writes unused bits as software loaded them; it does not clear them.
// - A read cycle first resets the key pointer; host issues it.
// - After full match, 64 cycles move data on line 0, direction by strobe.
module srtc_host
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic serial_data_line_o,
	output logic serial_data_line_oe,
	input wire logic serial_data_line_i,
	output logic abort_n
);
	srtc_cyc_if cyc();
	srtc_pkg::srtc_seq_e st_r, st_nxt;
	logic [63:0] key_r, key_nxt, img_r, img_nxt, rd_r, rd_nxt;
	logic [6:0] idx_r, idx_nxt;
	logic wdir_r, wdir_nxt, done_r, done_nxt;
	logic req_r, req_nxt, wbit_r, wbit_nxt;
	srtc_pkg::srtc_cyc_e kind_r, kind_nxt;
	logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt, abt_r;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic sin_m_r, sin_r;

	// Merges a 32-bit word into one half of a 64-bit image under byte strobes.
	function automatic logic [31:0] srtc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// The data pin comes from outside, so two flops precede any use.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			sin_m_r <= 1'b0;
			sin_r <= 1'b0;
			abt_r <= 1'b1;
		end
		else
		begin
			sin_m_r <= serial_data_line_i;
			sin_r <= sin_m_r;
			abt_r <= 1'b1; // Held high so a transfer is never cut short by us.
		end
	end

	// Bus slave and sequencer next state; one write and one read at a time.
	always_comb
	begin
		aw_nxt = aw_r;
		w_nxt = w_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		bv_nxt = bv_r;
		bresp_nxt = bresp_r;
		rv_nxt = rv_r;
		rdat_nxt = rdat_r;
		rresp_nxt = rresp_r;
		key_nxt = key_r;
		img_nxt = img_r;
		rd_nxt = rd_r;
		st_nxt = st_r;
		idx_nxt = idx_r;
		wdir_nxt = wdir_r;
		done_nxt = done_r;
		req_nxt = req_r;
		kind_nxt = kind_r;
		wbit_nxt = wbit_r;
		if (s_axi_awvalid && !aw_r && !bv_r)
		begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_r && !bv_r)
		begin
			w_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
		end
		if (aw_r && w_r)
		begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			bresp_nxt = 2'b00;
			case (awa_r)
				`SRTC_OFF_CTRL:
				begin
					if (wd_r[`SRTC_CTRL_GO] && st_r == srtc_pkg::SRTC_IDLE)
					begin
						wdir_nxt = wd_r[`SRTC_CTRL_WRITE];
						st_nxt = srtc_pkg::SRTC_SYNC_RD;
					end
				end
				`SRTC_OFF_STATUS:
					if (wd_r[`SRTC_STAT_DONE])
						done_nxt = 1'b0;
				`SRTC_OFF_KEY_LO: key_nxt[31:0] = srtc_merge(key_r[31:0], wd_r, ws_r);
				`SRTC_OFF_KEY_HI: key_nxt[63:32] = srtc_merge(key_r[63:32], wd_r, ws_r);
				// Whole words written keep each time register intact.
				`SRTC_OFF_TIME_LO: img_nxt[31:0] = srtc_merge(img_r[31:0], wd_r, ws_r);
				`SRTC_OFF_TIME_HI: img_nxt[63:32] = srtc_merge(img_r[63:32], wd_r, ws_r);
				default: bresp_nxt = 2'b10;
			endcase
		end
		if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
		if (s_axi_arvalid && !rv_r)
		begin
			rv_nxt = 1'b1;
			rresp_nxt = 2'b00;
			case (s_axi_araddr)
				`SRTC_OFF_CTRL: rdat_nxt = {31'h0, wdir_r};
				`SRTC_OFF_STATUS: rdat_nxt = {30'h0, done_r, st_r != srtc_pkg::SRTC_IDLE};
				`SRTC_OFF_KEY_LO: rdat_nxt = key_r[31:0];
				`SRTC_OFF_KEY_HI: rdat_nxt = key_r[63:32];
				`SRTC_OFF_TIME_LO: rdat_nxt = img_r[31:0];
				`SRTC_OFF_TIME_HI: rdat_nxt = img_r[63:32];
				// Format, PM, abort-mask, oscillator and zero bits pass verbatim.
				// Field layout is the device's, kept bit for bit.
				`SRTC_OFF_RD_LO: rdat_nxt = rd_r[31:0]; // BCD as the device sends.
				`SRTC_OFF_RD_HI: rdat_nxt = rd_r[63:32];
				default:
				begin
					rdat_nxt = 32'h0;
					rresp_nxt = 2'b10;
				end
			endcase
		end
		else if (rv_r && s_axi_rready)
			rv_nxt = 1'b0;
		// Sequencer: one read, 64 key writes, 64 data cycles, then idle.
		case (st_r)
			srtc_pkg::SRTC_IDLE: req_nxt = 1'b0;
			srtc_pkg::SRTC_SYNC_RD:
			begin
				req_nxt = 1'b1;
				kind_nxt = srtc_pkg::SRTC_CYC_READ; // Pointer back to first key bit.
				if (cyc.done)
				begin
					req_nxt = 1'b0;
					idx_nxt = 7'd0;
					st_nxt = srtc_pkg::SRTC_KEY;
				end
			end
			srtc_pkg::SRTC_KEY:
			begin
				req_nxt = !cyc.done;
				kind_nxt = srtc_pkg::SRTC_CYC_WRITE;
				wbit_nxt = key_r[idx_r[5:0]]; // Key goes out LSB first.
				if (cyc.done)
				begin
					idx_nxt = idx_r + 7'd1;
					if (idx_r == 7'(`SRTC_PATTERN_BITS - 1))
					begin
						idx_nxt = 7'd0;
						st_nxt = srtc_pkg::SRTC_DATA;
					end
				end
			end
			srtc_pkg::SRTC_DATA:
			begin
				// Direction picked by strobe; bit order reg0 bit0 to reg7 bit7.
				req_nxt = !cyc.done;
				kind_nxt = wdir_r ? srtc_pkg::SRTC_CYC_WRITE : srtc_pkg::SRTC_CYC_READ;
				wbit_nxt = img_r[idx_r[5:0]];
				if (cyc.done)
				begin
					rd_nxt[idx_r[5:0]] = cyc.rbit;
					idx_nxt = idx_r + 7'd1;
					if (idx_r == 7'(`SRTC_DATA_BITS - 1))
						st_nxt = srtc_pkg::SRTC_FIN;
				end
			end
			srtc_pkg::SRTC_FIN:
			begin
				// Next transfer starts again from the unlock read.
				req_nxt = 1'b0;
				done_nxt = 1'b1;
				st_nxt = srtc_pkg::SRTC_IDLE;
			end
			default: st_nxt = srtc_pkg::SRTC_IDLE;
		endcase
		awrdy_nxt = !aw_nxt && !bv_nxt;
		wrdy_nxt = !w_nxt && !bv_nxt;
		ardy_nxt = !rv_nxt;
	end

	// Registers of the bus slave and sequencer.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awa_r <= 8'h00;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			awrdy_r <= 1'b1;
			wrdy_r <= 1'b1;
			ardy_r <= 1'b1;
			bv_r <= 1'b0;
			bresp_r <= 2'b00;
			rv_r <= 1'b0;
			rdat_r <= 32'h0;
			rresp_r <= 2'b00;
			key_r <= `SRTC_KEY_RESET;
			img_r <= 64'h0;
			rd_r <= 64'h0;
			st_r <= srtc_pkg::SRTC_IDLE;
			idx_r <= 7'h0;
			wdir_r <= 1'b0;
			done_r <= 1'b0;
			req_r <= 1'b0;
			kind_r <= srtc_pkg::SRTC_CYC_READ;
			wbit_r <= 1'b0;
		end
		else
		begin
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			awrdy_r <= awrdy_nxt;
			wrdy_r <= wrdy_nxt;
			ardy_r <= ardy_nxt;
			bv_r <= bv_nxt;
			bresp_r <= bresp_nxt;
			rv_r <= rv_nxt;
			rdat_r <= rdat_nxt;
			rresp_r <= rresp_nxt;
			key_r <= key_nxt;
			img_r <= img_nxt;
			rd_r <= rd_nxt;
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			wdir_r <= wdir_nxt;
			done_r <= done_nxt;
			req_r <= req_nxt;
			kind_r <= kind_nxt;
			wbit_r <= wbit_nxt;
		end
	end

	assign cyc.req = req_r;
	assign cyc.kind = kind_r;
	assign cyc.wbit = wbit_r;

	// The cycle engine drives the strobe pins straight from its flops.
	srtc_cycle u_cycle
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.cyc(cyc),
		.sdata_in(sin_r),
		.chip_en_n(chip_en_n),
		.out_en_n(out_en_n),
		.wr_en_n(wr_en_n),
		.sdata_out(serial_data_line_o),
		.sdata_oe(serial_data_line_oe)
	);

	assign s_axi_awready = awrdy_r;
	assign s_axi_wready = wrdy_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ardy_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rdat_r;
	assign s_axi_rresp = rresp_r;
	assign abort_n = abt_r;
endmodule

/* File: srtc_checker.sv */
// Purpose: Strobe and data-line checks on the serial RTC host.
// Assumes: Strobes are registered levels on core_clk.
// Notes: Watches only the pins that face the device.
`timescale 1ns/1ns
module srtc_checker
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic serial_data_line_o,
	input wire logic serial_data_line_oe,
	input wire logic abort_n
);
	// Every check shares the core clock and is quiet in reset.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	AST_ONE_DIR: assert property (!(!out_en_n && !wr_en_n))
		else $error("read and write strobes low together");
	AST_WR_DRIVES: assert property (!wr_en_n |-> serial_data_line_oe)
		else $error("write cycle without data drive");
	AST_RD_FLOATS: assert property (!out_en_n |-> !serial_data_line_oe)
		else $error("read cycle while driving data");
	AST_CE_FRAMES: assert property ((!out_en_n || !wr_en_n) |-> !chip_en_n)
		else $error("strobe low without chip enable");
	AST_ABORT_IDLE: assert property (abort_n)
		else $error("abort pin driven low");
	AST_LOW_SPAN: assert property ($fell(chip_en_n) |-> !chip_en_n [*7] ##1 chip_en_n)
		else $error("chip enable low phase not seven cycles");
	AST_HIGH_SPAN: assert property ($rose(chip_en_n) |-> chip_en_n [*7])
		else $error("chip enable high phase too short");
	AST_WBIT_HOLD: assert property (!wr_en_n && !$past(wr_en_n) |-> $stable(serial_data_line_o))
		else $error("write data moved inside a write cycle");
	cover property ($fell(wr_en_n));
	cover property ($fell(out_en_n));
	cover property ($rose(chip_en_n));
endmodule
bind srtc_host srtc_checker i_srtc_checker (.core_clk, .resetn, .chip_en_n, .out_en_n,
	.wr_en_n, .serial_data_line_o, .serial_data_line_oe, .abort_n);

/* File: srtc_dev_model.sv */
// Purpose: Behavioural model of the serial RTC behind SRAM strobes.
// Assumes: Strobes change only on core_clk edges.
// Notes: The timebase is frozen, so an image reads back as written.
`timescale 1ns/1ns
module srtc_dev_model
#(
	parameter logic [63:0] KEY = 64'h5a3c96e10f7bc248 // Arbitrary pattern.
)
(
	input wire logic core_clk,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic serial_data_line_o,
	input wire logic serial_data_line_oe,
	input wire logic abort_n,
	output logic serial_data_line_i
);
	localparam logic [63:0] MSK = 64'hff1f3f37bf7f7fff;
	logic [63:0] img = 64'h0;
	logic [63:0] sh = 64'h0;
	logic rd = 1'b0, wr = 1'b0, wb = 1'b0, ce_q = 1'b1, last = 1'b0, armed = 1'b0, unl = 1'b0;
	int ptr = 0, cnt = 0, nunl = 0;
	// A released line toggles, so a late sample cannot match by luck.
	assign serial_data_line_i = serial_data_line_oe ? serial_data_line_o :
		(unl && !chip_en_n && !out_en_n) ? img[cnt] : ~last;
	// A cycle is acted on when chip enable rises.
	always @(posedge core_clk)
	begin
		last <= serial_data_line_i;
		ce_q <= chip_en_n;
		if (!chip_en_n)
		begin
			rd <= !out_en_n;
			wr <= !wr_en_n;
			wb <= serial_data_line_o;
		end
		if (!abort_n && !img[36])
		begin
			armed <= 1'b0;
			unl <= 1'b0;
		end
		else if (chip_en_n && !ce_q)
		begin
			if (unl)
			begin
				sh[cnt] <= wb;
				cnt <= cnt + 1;
				if (cnt == 63)
				begin
					unl <= 1'b0;
					armed <= 1'b0;
					if (wr)
						img <= {wb, sh[62:0]} & MSK;
				end
			end
			else if (rd)
			begin
				ptr <= 0;
				armed <= 1'b1;
			end
			else if (armed && wb == KEY[ptr])
			begin
				ptr <= ptr + 1;
				if (ptr == 63)
				begin
					unl <= 1'b1;
					cnt <= 0;
					nunl <= nunl + 1;
				end
			end
			else
				armed <= 1'b0;
		end
	end
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the serial RTC host.
// Assumes: Model key equals the key loaded over the bus.
// Notes: Device time stands still, so read-back is the masked image.
`timescale 1ns/1ns
`include "srtc_defs.svh"
module tb_top;
	localparam logic [63:0] KEY = 64'h5a3c96e10f7bc248; // Arbitrary pattern.
	localparam logic [63:0] MSK = 64'hff1f3f37bf7f7fff;
	logic core_clk = 1'b0, resetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d, lo;
	logic chip_en_n, out_en_n, wr_en_n, serial_data_line_o, serial_data_line_oe;
	logic serial_data_line_i, abort_n;
	logic [63:0] img;
	int fails = 0, total_checks = 0, n;
	srtc_host i_srtc_host (.*);
	srtc_dev_model #(.KEY(KEY)) i_srtc_dev_model (.*);
	// Free-running core clock.
	always #5 core_clk = ~core_clk;
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	// Handshakes are judged at the falling edge, where inputs are settled.
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge core_clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		while (!tb);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		logic ta, tv;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge core_clk);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		while (!tv);
		s_axi_rready <= 1'b0;
	endtask
	task automatic go(input logic w);
		axw(`SRTC_OFF_CTRL, {30'h0, w, 1'b1});
		do
			axr(`SRTC_OFF_STATUS);
		while (d[`SRTC_STAT_DONE] !== 1'b1);
		axw(`SRTC_OFF_STATUS, 32'h2);
	endtask
	function automatic logic [7:0] bcd(input int v);
		return {4'(v / 10), 4'(v % 10)};
	endfunction
	// Image 0 also sets every unused bit, which the device must drop.
	function automatic logic [63:0] mkimg(input int k);
		logic [7:0] h;
		h = (k % 3 == 0) ? 8'hb2 : (k % 3 == 1) ? 8'h23 : 8'h81;
		return {bcd($urandom % 100), bcd($urandom % 12 + 1), bcd($urandom % 31 + 1),
			8'h10 | bcd($urandom % 7 + 1), h, bcd($urandom % 60), bcd($urandom % 60),
			bcd($urandom % 100)} | ((k == 0) ? ~MSK : 64'h0);
	endfunction
	task automatic results();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		void'($urandom(89));
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		axr(`SRTC_OFF_STATUS);
		chk("status", 64'h0, {r, d});
		axr(8'h20);
		chk("unmapped read", {2'b10, 32'h0}, {r, d});
		axw(8'h24, 32'h1);
		chk("unmapped write", 64'h2, r);
		$display("bus test done");
		axw(`SRTC_OFF_KEY_LO, KEY[31:0]);
		axw(`SRTC_OFF_KEY_HI, KEY[63:32]);
		for (int k = 0; k < 4; k++)
		begin
			img = mkimg(k);
			axw(`SRTC_OFF_TIME_LO, img[31:0]);
			axw(`SRTC_OFF_TIME_HI, img[63:32]);
			n = i_srtc_dev_model.nunl;
			go(1'b1);
			chk("device image", img & MSK, i_srtc_dev_model.img);
			go(1'b0);
			axr(`SRTC_OFF_RD_LO);
			lo = d;
			axr(`SRTC_OFF_RD_HI);
			chk("read back", img & MSK, {d, lo});
			chk("unlocks", 64'(n + 2), 64'(i_srtc_dev_model.nunl));
			$display("image test %0d done", k);
		end
		axw(`SRTC_OFF_KEY_HI, KEY[63:32] ^ 32'h100);
		axw(`SRTC_OFF_TIME_LO, 32'h0);
		go(1'b1);
		chk("bad key image", img & MSK, i_srtc_dev_model.img);
		chk("bad key unlocks", 64'(n + 2), 64'(i_srtc_dev_model.nunl));
		$display("bad key test done");
		results();
	end
	// Watchdog against a hung handshake.
	initial
	begin
		#500000;
		fails++;
		results();
	end
endmodule
